/* File: dv/rst_ctl_assertions.sv */
// Port checker for the reset source controller
`timescale 1ns/1ps
module rst_ctl_assertions
  import rst_ctl_pkg::*;
#(
  parameter int START_CYC = 20
) (
  // Clock, reset, register port, watchdog and mode
  input wire logic clk_sys_i,
  input wire logic rst_i,
  input wire rst_ctl_pkg::reg_req_t req_i,
  input wire logic [7:0] rdata_o,
  input wire logic wdt_timeout_i,
  input wire rst_ctl_pkg::power_mode_t mode_i,
  // Core side
  input wire logic core_rst_o,
  input wire logic [15:0] pc_o,
  input wire logic guard_en_o,
  input wire logic [7:0] level_code_o,
  input wire logic timeout_flag_o,
  input wire logic pdown_flag_o
);
  int run_q;
  default clocking cb @(posedge clk_sys_i);
  endclocking
  default disable iff (rst_i);
  // Length of the reset pulse standing now
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) run_q <= 0;
    else run_q <= core_rst_o ? run_q + 1 : 0;
  end
  sequence key_write_s;
    req_i.wr && req_i.addr == 4'h2 && req_i.wdata == 8'h55;
  endsequence
  sequence asleep_s;
    (mode_i == IDLE_MODE || mode_i == SLEEP_MODE) [*2];
  endsequence
  pc_zero_a: assert property (pc_o == 16'h0000)
    else $error("pc not zero");
  start_len_a: assert property ($fell(core_rst_o) |->
    $past(run_q) >= START_CYC - 1) else $error("start delay short");
  sleep_off_a: assert property (asleep_s |-> !guard_en_o)
    else $error("guard on asleep");
  ro_bits_a: assert property (level_code_o[3:2] == 2'h1)
    else $error("threshold ro bits");
  flag_top_a: assert property (req_i.rd && req_i.addr == 4'h1 |=>
    rdata_o[7:3] == 5'h00) else $error("cause top bits");
  prog_rst_a: assert property (key_write_s |-> ##[1:3] core_rst_o)
    else $error("program reset missing");
  wdt_rst_a: assert property (wdt_timeout_i && !core_rst_o &&
    mode_i == RUN_MODE |-> ##[1:3] (core_rst_o && timeout_flag_o))
    else $error("timeout reset missing");
  por_flags_a: assert property ($fell(rst_i) |->
    !timeout_flag_o && !pdown_flag_o) else $error("flags after power-on");
endmodule : rst_ctl_assertions
bind rst_ctl rst_ctl_assertions #(.START_CYC(START_CYC)) u_chk (
  .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req_i), .rdata_o(rdata_o),
  .wdt_timeout_i(wdt_timeout_i), .mode_i(mode_i), .core_rst_o(core_rst_o),
  .pc_o(pc_o), .guard_en_o(guard_en_o), .level_code_o(level_code_o),
  .timeout_flag_o(timeout_flag_o), .pdown_flag_o(pdown_flag_o));

/* File: dv/rst_ctl_partner.sv */
// Far-side model: RC reset network and supply comparator
`timescale 1ns/1ps
module rst_ctl_partner #(
  parameter int RC_CYC = 3
) (
  // Clock and stimulus
  input wire logic clk_sys_i,
  input wire logic hold_i,
  input wire logic sag_i,
  // Pins
  output logic clear_pin_n_o,
  output logic supply_low_o
);
  int cnt_q = 0;
  // Capacitor charge lags the release
  always @(posedge clk_sys_i) cnt_q <= hold_i ? RC_CYC : cnt_q - (cnt_q > 0);
  assign clear_pin_n_o = !hold_i && cnt_q == 0;
  assign supply_low_o = sag_i;
endmodule : rst_ctl_partner

/* File: dv/testbench.sv */
// Self-checking bench for the reset source controller
`timescale 1ns/1ps
module testbench;
  import rst_ctl_pkg::*;
  logic clk_sys_i = 0, rst_i = 1, opt = 1, hold = 0, sag = 0, wdt = 0;
  logic halt = 0, clrpd = 0, rd_seen = 0, pin_n, low, crst, pp, gen, tof, pdn;
  logic [7:0] rdata, r, lvl;
  logic [15:0] pc;
  logic [7:0] exp_q[$];
  reg_req_t req = '0;
  power_mode_t mode = RUN_MODE;
  int num_errors = 0, check_count = 0, k;
  always #12.5 clk_sys_i = ~clk_sys_i;
  rst_ctl_partner u_far (.clk_sys_i(clk_sys_i), .hold_i(hold), .sag_i(sag),
    .clear_pin_n_o(pin_n), .supply_low_o(low));
  rst_ctl #(.START_CYC(20), .FILTER_CYC(4), .SUB_DIV(4)) u_dut (
    .clk_sys_i(clk_sys_i), .rst_i(rst_i), .req_i(req), .rdata_o(rdata),
    .clear_pin_n_i(pin_n), .clear_pin_opt_i(opt), .supply_low_i(low),
    .wdt_timeout_i(wdt), .halt_i(halt), .clr_pd_i(clrpd), .mode_i(mode),
    .core_rst_o(crst), .pc_o(pc), .port_preset_o(pp), .guard_en_o(gen),
    .level_code_o(lvl), .timeout_flag_o(tof), .pdown_flag_o(pdn));
  task automatic chk(input logic [15:0] got, exp);
    check_count++;
    if (got !== exp) begin
      num_errors++;
      $display("mismatch at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk
  task automatic tick(input int n);
    repeat (n) @(posedge clk_sys_i);
  endtask : tick
  // Read notes the wanted data, the monitor pairs it later
  task automatic bus(input logic w, input logic [3:0] a, input logic [7:0] d);
    tick(1);
    req <= '{a, d, w, !w};
    if (!w) exp_q.push_back(d);
    tick(1);
    req <= '0;
  endtask : bus
  task automatic rst_in(input int n, input logic e);
    for (k = 0; k < n && crst !== 1'b1; k++) @(negedge clk_sys_i);
    chk(crst, e);
    for (k = 0; k < 200 && crst !== 1'b0; k++) @(negedge clk_sys_i);
    chk(crst, 1'b0);
  endtask : rst_in
  task automatic drop_after(input int n);
    fork
      begin
        tick(n);
        hold <= 0;
        sag <= 0;
      end
    join_none
  endtask : drop_after
  task automatic final_report;
    $display("checks %0d mismatches %0d", check_count, num_errors);
    if (num_errors == 0 && check_count > 0) $display("TB: PASS");
    else $display("TB: FAIL");
    $finish;
  endtask : final_report
  always @(negedge clk_sys_i) begin
    if (rd_seen) chk(rdata, exp_q.pop_front());
    rd_seen = req.rd;
  end
  initial begin
    tick(6000);
    num_errors++;
    final_report();
  end
  initial begin
    void'($urandom(93));
    tick(12);
    chk(pp, 1);
    rst_i <= 0;
    rst_in(1, 1);
    chk(k >= 19, 1);
    chk(pc, 16'h0000);
    bus(0, 4'h0, 8'h66);
    chk(pp, 0);
    bus(0, 4'h1, 8'h00);
    bus(0, 4'h3, 8'h53);
    bus(0, 4'h9, 8'h00);
    bus(1, 4'h0, 8'h55);
    bus(0, 4'h0, 8'h55);
    $display("test registers done");
    r = $urandom;
    r[3:2] = 2'h1;
    if (r == 8'h66 || r == 8'h55) r = 8'h05;
    bus(1, 4'h0, r);
    rst_in(24, 1);
    bus(0, 4'h0, 8'h66);
    chk(lvl, 8'h66);
    bus(0, 4'h1, 8'h02);
    bus(1, 4'h1, 8'h00);
    bus(0, 4'h1, 8'h00);
    bus(1, 4'h0, 8'h55);
    tick(1);
    sag <= 1;
    drop_after(2);
    rst_in(30, 0);
    tick(1);
    sag <= 1;
    drop_after(30);
    rst_in(40, 1);
    bus(0, 4'h0, 8'h55);
    chk(lvl, 8'h55);
    bus(0, 4'h1, 8'h04);
    $display("test supply done");
    bus(1, 4'h2, 8'h55);
    rst_in(4, 1);
    bus(1, 4'h3, 8'h03);
    rst_in(24, 1);
    bus(0, 4'h1, 8'h05);
    tick(1);
    halt <= 1;
    wdt <= 1;
    tick(1);
    halt <= 0;
    wdt <= 0;
    rst_in(4, 1);
    bus(0, 4'h4, 8'h0E);
    $display("test sources done");
    tick(1);
    opt <= 0;
    hold <= 1;
    drop_after(6);
    rst_in(10, 0);
    tick(6);
    opt <= 1;
    hold <= 1;
    drop_after(12);
    rst_in(6, 1);
    chk(k >= 30, 1);
    chk({tof, pdn}, 2'h3);
    tick(1);
    mode <= SLEEP_MODE;
    tick(3);
    chk(gen, 0);
    mode <= IDLE_MODE;
    wdt <= 1;
    tick(1);
    wdt <= 0;
    tick(2);
    chk(gen, 0);
    chk(crst, 0);
    mode <= SLOW_MODE;
    tick(3);
    chk(gen, 1);
    mode <= RUN_MODE;
    clrpd <= 1;
    tick(1);
    clrpd <= 0;
    tick(2);
    chk(pdn, 0);
    $display("test pin and modes done");
    rst_i <= 1;
    tick(2);
    chk(pp, 1);
    rst_i <= 0;
    rst_in(1, 1);
    chk(tof, 0);
    bus(0, 4'h1, 8'h00);
    $display("test power-on done");
    final_report();
  end
endmodule : testbench

/* File: rtl/rst_ctl.sv */
// Reset source controller: sources, cause flags, start-up delay
//
// Notes on behaviour
// - Program counter clears to zero on power-on.
// - Port data and direction preset all ones.
// - Low clear pin holds reset, resumes after.
// - Clear pin acts only when option selects.
// - Start delay follows clear pin release.
// - Supply droop resets and sets droop flag.
// - Short droop indications are filtered out.
// - Guard off in sleep and idle modes.
// - Level code selects threshold or disable; read-only bits 3:2 allow only 66h and 55h to stand, never disable.
// - Undefined code resets, flags, restores default.
// - Genuine droop reset keeps threshold unchanged.
// - Threshold resets to 66h, bits 3:2 read-only.
// - Cause flags set by hardware, cleared by software.
// - Upper five flag bits read zero.
// - Writing 55h to program control resets.
// - Watchdog time-out resets in run and slow modes and sets expired flag.
// - Droop reset is full reset with delay.
// - Bad watchdog key resets and flags.
// - Power-on clears expired and power-down flags.
//
// The implementer's own choices: the address map and strobed register access.
`timescale 1ns/1ps
`include "rst_ctl_defines.svh"
module rst_ctl
  import rst_ctl_pkg::*;
#(
  parameter int START_CYC = `START_DELAY_CYC,
  parameter int FILTER_CYC = 400,
  parameter int SUB_DIV = `SUB_DIV
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Register port
  input wire rst_ctl_pkg::reg_req_t req_i,
  output logic [7:0] rdata_o,
  // Pins and monitors
  input wire logic clear_pin_n_i,
  input wire logic clear_pin_opt_i,
  input wire logic supply_low_i,
  input wire logic wdt_timeout_i,
  input wire logic halt_i,
  input wire logic clr_pd_i,
  input wire rst_ctl_pkg::power_mode_t mode_i,
  // Outputs to the core
  output logic core_rst_o,
  output logic [15:0] pc_o,
  output logic port_preset_o,
  output logic guard_en_o,
  output logic [7:0] level_code_o,
  output logic timeout_flag_o,
  output logic pdown_flag_o
);
  import rst_ctl_pkg::*;

  function automatic logic level_known(input logic [7:0] c);
    return c == `LVL_1V7 || c == `LVL_1V9 || c == `LVL_2V55 ||
           c == `LVL_3V15 || c == `LVL_3V8 || c == `LVL_OFF;
  endfunction : level_known

  function automatic logic key_known(input logic [4:0] k);
    return k == `WDT_KEY_OFF || k == `WDT_KEY_ON;
  endfunction : key_known

  // One write decode shared by every register
  function automatic logic wr_hit(input reg_req_t r, input logic [3:0] a);
    return r.wr && r.addr == a;
  endfunction : wr_hit

  logic tick;
  logic [7:0] level_q;
  logic [7:0] wkey_q;
  logic droop_flag_q;
  logic badlvl_flag_q;
  logic badkey_flag_q;
  logic cause_wr;
  logic por_q;
  logic [31:0] delay_q;
  logic [15:0] filt_q;
  logic droop_req;
  logic droop_fire;
  logic badlvl_fire;
  logic badkey_fire;
  logic prog_hit;
  logic pin_rst;
  logic wdt_rst;
  logic src_any;
  logic guard_on;
  logic sleepy;
  rst_src_t src;

  sub_tick_gen #(.DIV(SUB_DIV)) u_tick (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_o(tick)
  );

  assign sleepy = (mode_i == IDLE_MODE) || (mode_i == SLEEP_MODE);
  assign guard_on = !sleepy && (level_q != `LVL_OFF);
  assign pin_rst = clear_pin_opt_i && !clear_pin_n_i;
  assign wdt_rst = wdt_timeout_i && !sleepy;
  assign prog_hit = wr_hit(req_i, `ADDR_PROG_CTRL) &&
                    req_i.wdata == `PROG_RST_KEY;
  assign cause_wr = wr_hit(req_i, `ADDR_CAUSE);

  // Filter keeps noise spikes on the comparator from resetting
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      filt_q <= 16'h0000;
    end else if (!supply_low_i || !guard_on || core_rst_o) begin
      filt_q <= 16'h0000;
    end else if (filt_q != 16'(FILTER_CYC)) begin
      filt_q <= filt_q + 16'h0001;
    end
  end
  assign droop_req = guard_on && level_known(level_q) &&
                     filt_q == 16'(FILTER_CYC);

  sub_delay_arm u_droop (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .req_i(droop_req && !core_rst_o),
    .fire_o(droop_fire)
  );

  sub_delay_arm u_badlvl (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .req_i(!level_known(level_q)),
    .fire_o(badlvl_fire)
  );

  sub_delay_arm u_badkey (
    .clk_sys_i(clk_sys_i),
    .rst_i(rst_i),
    .tick_i(tick),
    .req_i(!key_known(wkey_q[7:3])),
    .fire_o(badkey_fire)
  );

  always_comb begin
    src = '0;
    src.por = por_q;
    src.pin = pin_rst;
    src.droop = droop_fire;
    src.bad_level = badlvl_fire;
    src.bad_key = badkey_fire;
    src.prog = prog_hit;
    src.wdt = wdt_rst;
  end
  assign src_any = |src;

  // Power-on marker released one cycle after the async reset
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      por_q <= 1'b1;
    end else begin
      por_q <= 1'b0;
    end
  end

  // Threshold register; a genuine droop leaves it alone
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level_q <= `LVL_POR;
    end else if (badlvl_fire) begin
      level_q <= `LVL_POR;
    end else if (wr_hit(req_i, `ADDR_LVL_SEL)) begin
      level_q <= (req_i.wdata & ~`LVL_RO_MASK) |
                 (level_q & `LVL_RO_MASK);
    end
  end

  // Watchdog key; bad key is cleared by the reset it causes
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      wkey_q <= `WDT_KEY_POR;
    end else if (badkey_fire) begin
      wkey_q <= `WDT_KEY_POR;
    end else if (wr_hit(req_i, `ADDR_WDT_KEY)) begin
      wkey_q <= req_i.wdata;
    end
  end

  // Droop flag; a set in the clearing cycle wins so no event is lost
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      droop_flag_q <= 1'b0;
    end else if (droop_fire) begin
      droop_flag_q <= 1'b1;
    end else if (cause_wr && !req_i.wdata[`BIT_DROOP]) begin
      droop_flag_q <= 1'b0;
    end
  end

  // Bad level flag; writing one leaves it alone
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      badlvl_flag_q <= 1'b0;
    end else if (badlvl_fire) begin
      badlvl_flag_q <= 1'b1;
    end else if (cause_wr && !req_i.wdata[`BIT_BADLVL]) begin
      badlvl_flag_q <= 1'b0;
    end
  end

  // Bad key flag; only power-on or software clears it
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      badkey_flag_q <= 1'b0;
    end else if (badkey_fire) begin
      badkey_flag_q <= 1'b1;
    end else if (cause_wr && !req_i.wdata[`BIT_BADKEY]) begin
      badkey_flag_q <= 1'b0;
    end
  end

  // Time-out flag survives every reset but power-on
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      timeout_flag_o <= 1'b0;
    end else if (wdt_timeout_i) begin
      timeout_flag_o <= 1'b1;
    end
  end

  // Power-down flag; a halt beats a clear in the same cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pdown_flag_o <= 1'b0;
    end else if (halt_i) begin
      pdown_flag_o <= 1'b1;
    end else if (clr_pd_i) begin
      pdown_flag_o <= 1'b0;
    end
  end

  // Start-up timer restarts while any source is active
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      delay_q <= 32'h0000_0000;
      core_rst_o <= 1'b1;
    end else if (src_any) begin
      delay_q <= 32'h0000_0000;
      core_rst_o <= 1'b1;
    end else if (core_rst_o) begin
      if (delay_q == 32'(START_CYC - 1)) begin
        core_rst_o <= 1'b0;
      end else begin
        delay_q <= delay_q + 32'h0000_0001;
      end
    end
  end

  // Program counter is held at zero while any reset stands
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      pc_o <= 16'h0000;
    end else if (src_any || core_rst_o) begin
      pc_o <= 16'h0000;
    end
  end

  // Port preset trails the combined reset by one cycle
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      port_preset_o <= 1'b1;
    end else begin
      port_preset_o <= src_any || core_rst_o;
    end
  end

  // Guard enable follows the power mode
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      guard_en_o <= 1'b0;
    end else begin
      guard_en_o <= guard_on;
    end
  end

  // Registered copy keeps the core side off the bus timing
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      level_code_o <= `LVL_POR;
    end else begin
      level_code_o <= level_q;
    end
  end

  // Read data one cycle after strobe, zero otherwise
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      rdata_o <= 8'h00;
    end else if (req_i.rd) begin
      unique case (req_i.addr)
        `ADDR_LVL_SEL: rdata_o <= level_q;
        `ADDR_CAUSE: rdata_o <= {5'h00, droop_flag_q, badlvl_flag_q,
                                 badkey_flag_q};
        `ADDR_WDT_KEY: rdata_o <= wkey_q;
        `ADDR_STATUS: rdata_o <= {4'h0, pdown_flag_o, timeout_flag_o,
                                  guard_on, core_rst_o};
        default: rdata_o <= 8'h00;
      endcase
    end else begin
      rdata_o <= 8'h00;
    end
  end
endmodule : rst_ctl

/* File: rtl/rst_ctl_defines.svh */
// Constants for the reset source controller
`ifndef RST_CTL_DEFINES_SVH
`define RST_CTL_DEFINES_SVH
`define ADDR_LVL_SEL 4'h0
`define ADDR_CAUSE 4'h1
`define ADDR_PROG_CTRL 4'h2
`define ADDR_WDT_KEY 4'h3
`define ADDR_STATUS 4'h4
`define LVL_POR 8'h66
`define LVL_1V7 8'h66
`define LVL_1V9 8'h55
`define LVL_2V55 8'h33
`define LVL_3V15 8'h99
`define LVL_3V8 8'hAA
`define LVL_OFF 8'hF0
`define LVL_RO_MASK 8'h0C
`define WDT_KEY_POR 8'h53
`define WDT_KEY_OFF 5'h15
`define WDT_KEY_ON 5'h0A
`define PROG_RST_KEY 8'h55
`define BIT_DROOP 2
`define BIT_BADLVL 1
`define BIT_BADKEY 0
`define CLK_HZ 40000000
`define START_DELAY_MS 50
`define START_DELAY_CYC ((`CLK_HZ / 1000) * `START_DELAY_MS)
`define SUB_DIV 1220
`define SUB_DELAY_LO 2
`endif

/* File: rtl/rst_ctl_pkg.sv */
// Types for the reset source controller
package rst_ctl_pkg;
  typedef enum logic [1:0] {
    RUN_MODE,
    SLOW_MODE,
    IDLE_MODE,
    SLEEP_MODE
  } power_mode_t;
  typedef struct packed {
    logic [3:0] addr;
    logic [7:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;
  typedef struct packed {
    logic por;
    logic pin;
    logic droop;
    logic bad_level;
    logic bad_key;
    logic prog;
    logic wdt;
  } rst_src_t;
endpackage : rst_ctl_pkg

/* File: rtl/sub_delay_arm.sv */
// Delays a level request by two to three subclock ticks
`timescale 1ns/1ps
module sub_delay_arm (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Control
  input wire logic tick_i,
  input wire logic req_i,
  output logic fire_o
);
  logic [1:0] cnt_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 2'h0;
    end else if (!req_i) begin
      cnt_q <= 2'h0;
    end else if (tick_i && cnt_q != 2'h3) begin
      cnt_q <= cnt_q + 2'h1;
    end
  end
  // Partial first tick gives the 2 to 3 spread
  assign fire_o = req_i && tick_i && (cnt_q == 2'h2);
endmodule : sub_delay_arm

/* File: rtl/sub_tick_gen.sv */
// Subclock enable pulse divider
`timescale 1ns/1ps
module sub_tick_gen #(
  parameter int DIV = 1220
) (
  // Clock and reset
  input wire logic clk_sys_i,
  input wire logic rst_i,
  // Tick
  output logic tick_o
);
  logic [15:0] cnt_q;
  always_ff @(posedge clk_sys_i or posedge rst_i) begin
    if (rst_i) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b0;
    end else if (cnt_q == 16'(DIV - 1)) begin
      cnt_q <= 16'h0000;
      tick_o <= 1'b1;
    end else begin
      cnt_q <= cnt_q + 16'h0001;
      tick_o <= 1'b0;
    end
  end
endmodule : sub_tick_gen
